/* File: design/audio_rx_pkg.sv */
// constants and types for the stereo serial audio input port
// Summary of operation
// [R01] words are two's complement, most significant bit first
// [R02] left word precedes right word in every frame
// [R03] left-justified, I2S, DSP accept up to 24 bits, extra bits dropped silently
// [R04] right-justified length 16, 20 or 24 bits, 24 after power-up
// [R05] source gives exactly 64 bit clocks per frame in right-justified mode
// [R06] left-justified: word select high is left, rising edge, MSB without delay
// [R07] I2S is default: word select low is left, MSB one bit late
// [R08] right-justified: high is left, data starts 8, 12 or 16 bits late
// [R09] DSP: source pulses word select high one bit before each MSB
// [R10] DSP: data captured on falling bit clock edges, up to 24 bits
// [R11] DSP: source sends left with first pulse, then strict alternation
// [R12] word select toggles at sample rate, pulses at twice it in DSP
// [R13] bit clock 64 times word select, bursts allowed except right-justified
// [R14] boot period of 1024 clock cycles starts at reset release
// [R15] host makes no control access during the boot period
// [R16] mode field: 00 I2S, 01 right-justified, 10 DSP, 11 left-justified
// [R17] length field: 00 is 24, 01 is 20, 10 and 11 are 16 bits
// [R18] left and right word delivered together with one-cycle valid strobe; here SAMPLE_VALID_O is held until SAMPLE_READY_I
package audio_rx_pkg;
  localparam int WORD_BITS = 24;
  localparam int STEREO_BITS = 2 * WORD_BITS;
  localparam int FIFO_DEPTH = 8;
  localparam logic [1:0] MODE_I2S = 2'h0;
  localparam logic [1:0] MODE_RJ = 2'h1;
  localparam logic [1:0] MODE_DSP = 2'h2;
  localparam logic [1:0] MODE_LJ = 2'h3;
  localparam logic [1:0] WLEN_24 = 2'h0;
  localparam logic [1:0] WLEN_20 = 2'h1;
  localparam logic [5:0] LJ_START = 6'h00;
  localparam logic [5:0] I2S_START = 6'h01;
  localparam logic [5:0] DSP_START = 6'h00;
  localparam logic [5:0] RJ_START_24 = 6'h08;
  localparam logic [5:0] RJ_START_20 = 6'h0C;
  localparam logic [5:0] RJ_START_16 = 6'h10;
  localparam logic [5:0] LEN_24 = 6'h18;
  localparam logic [5:0] LEN_20 = 6'h14;
  localparam logic [5:0] LEN_16 = 6'h10;
  localparam logic [5:0] IDX_MAX = 6'h3F;
  localparam logic [10:0] BOOT_CYCLES = 11'h400;
  localparam int PIN_BCLK = 0;
  localparam int PIN_WS = 1;
  localparam int PIN_DATA = 2;

  typedef enum logic [1:0] {FMT_I2S, FMT_RJ, FMT_DSP, FMT_LJ} fmt_t;

  typedef struct packed {
    logic [WORD_BITS-1:0] left;
    logic [WORD_BITS-1:0] right;
  } stereo_t;
endpackage : audio_rx_pkg

/* File: design/audio_serial_rx.sv */
// stereo serial audio input port with boot period and sample buffer
`timescale 1ns/1ps
`default_nettype none
module audio_serial_rx
  import audio_rx_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic BCLK_I,
  input wire logic WS_I,
  input wire logic SDATA_I,
  input wire logic [1:0] MODE_I,
  input wire logic [1:0] WORD_LEN_I,
  output logic BOOT_BUSY_O,
  output logic OVERRUN_O,
  output wire logic SAMPLE_VALID_O,
  output wire stereo_t SAMPLE_O,
  input wire logic SAMPLE_READY_I
);
  typedef struct packed {
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] pins;
    logic [10:0] boot_cnt;
    logic busy;
    logic primed;
    logic active;
    logic ws_prev;
    logic cur_right;
    logic [5:0] idx;
    logic [WORD_BITS-1:0] word;
    logic [WORD_BITS-1:0] left_word;
    logic have_left;
    logic push;
    stereo_t push_data;
    logic overrun;
    logic [1:0] mode_prev;
  } rx_state_t;

  rx_state_t st;
  rx_state_t next_st;
  fmt_t fmt;
  logic fifo_ready;
  logic [2:0] agree;
  logic bclk_rise;
  logic bclk_fall;
  logic sample_edge;
  logic ws;
  logic data;
  logic [5:0] start;
  logic [5:0] len;
  logic finish;
  logic done_right;
  logic restart;
  logic capture_en;
  logic [5:0] cur_idx;
  logic [5:0] pos;
  logic [4:0] bit_at;
  logic [WORD_BITS-1:0] base_word;

  // [R16] mode field decode
  always_comb begin
    case (MODE_I)
      MODE_I2S: fmt = FMT_I2S;
      MODE_RJ: fmt = FMT_RJ;
      MODE_DSP: fmt = FMT_DSP;
      MODE_LJ: fmt = FMT_LJ;
      default: fmt = FMT_I2S;
    endcase
  end

  // first data bit position and word length per format
  always_comb begin
    case (fmt)
      FMT_I2S: begin
        // [R07] MSB one bit late
        start = I2S_START;
        // [R03] cut after 24 bits
        len = LEN_24;
      end
      FMT_LJ: begin
        // [R06] MSB without delay
        start = LJ_START;
        len = LEN_24;
      end
      FMT_DSP: begin
        // [R10] up to 24 bits
        start = DSP_START;
        len = LEN_24;
      end
      FMT_RJ: begin
        // [R17] length field decode
        case (WORD_LEN_I)
          WLEN_24: begin
            // [R08] start offset per length
            start = RJ_START_24;
            // [R04] selectable length
            len = LEN_24;
          end
          WLEN_20: begin
            start = RJ_START_20;
            len = LEN_20;
          end
          default: begin
            start = RJ_START_16;
            len = LEN_16;
          end
        endcase
      end
      default: begin
        start = I2S_START;
        len = LEN_24;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    next_st.push = 1'b0;
    next_st.overrun = 1'b0;
    next_st.mode_prev = MODE_I;
    // three-stage pin sampling, accept when stages two and three agree
    next_st.sync1 = {SDATA_I, WS_I, BCLK_I};
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;
    agree = ~(st.sync2 ^ st.sync3);
    next_st.pins = (agree & st.sync3) | (~agree & st.pins);
    bclk_rise = next_st.pins[PIN_BCLK] & ~st.pins[PIN_BCLK];
    bclk_fall = ~next_st.pins[PIN_BCLK] & st.pins[PIN_BCLK];
    ws = next_st.pins[PIN_WS];
    data = next_st.pins[PIN_DATA];
    // [R10] falling edge in DSP, else rising
    sample_edge = (fmt == FMT_DSP) ? bclk_fall : bclk_rise;
    finish = 1'b0;
    done_right = 1'b0;
    restart = 1'b0;
    capture_en = 1'b0;
    if (fmt == FMT_DSP) begin
      // [R11] first pulse opens left, then alternate
      finish = ws & ~st.ws_prev & st.active;
      done_right = st.cur_right;
      restart = ws;
      capture_en = ~ws & st.active;
    end else begin
      finish = (ws != st.ws_prev) & st.active;
      // [R06] high is left in left- and right-justified
      done_right = ~st.ws_prev;
      if (fmt == FMT_I2S) begin
        // [R07] low is left in I2S
        done_right = st.ws_prev;
      end
      restart = (ws != st.ws_prev);
      capture_en = st.active | restart;
    end
    cur_idx = restart ? 6'h00 : st.idx;
    base_word = restart ? '0 : st.word;
    pos = cur_idx - start;
    bit_at = 5'(WORD_BITS - 1) - pos[4:0];
    // [R14] boot period count
    if (st.busy) begin
      next_st.boot_cnt = st.boot_cnt + 1'b1;
      if (st.boot_cnt == BOOT_CYCLES - 11'h001) begin
        next_st.busy = 1'b0;
      end
      next_st.primed = 1'b0;
      next_st.active = 1'b0;
      next_st.have_left = 1'b0;
      next_st.cur_right = 1'b0;
      next_st.word = '0;
      next_st.left_word = '0;
    end else if (MODE_I != st.mode_prev) begin
      next_st.primed = 1'b0;
      next_st.active = 1'b0;
      next_st.have_left = 1'b0;
      next_st.cur_right = 1'b0;
    end else if (sample_edge) begin
      next_st.ws_prev = ws;
      next_st.primed = 1'b1;
      if (st.primed) begin
        // [R02] left held, right completes the pair
        if (finish) begin
          if (!done_right) begin
            next_st.left_word = st.word;
            next_st.have_left = 1'b1;
          end else if (st.have_left) begin
            next_st.have_left = 1'b0;
            // [R18] pair pushed with one-cycle strobe
            next_st.push = 1'b1;
            next_st.push_data.left = st.left_word;
            next_st.push_data.right = st.word;
          end
          if (fmt == FMT_DSP) begin
            next_st.cur_right = ~st.cur_right;
          end
        end
        if (fmt == FMT_DSP) begin
          if (ws && !st.ws_prev) begin
            next_st.active = 1'b1;
          end
        end else if (restart) begin
          next_st.active = 1'b1;
        end
        // [R01] MSB first into top bit
        next_st.word = base_word;
        if (capture_en && (cur_idx >= start) && (pos < len)) begin
          next_st.word[bit_at] = data;
        end
        // [R10] dsp index counts from first low bit
        if ((fmt == FMT_DSP) && ws) begin
          next_st.idx = 6'h00;
        end else begin
          // [R13] index saturates for burst clocks
          next_st.idx = (cur_idx == IDX_MAX) ? IDX_MAX : cur_idx + 6'h01;
        end
      end
    end
    // dropped pair when buffer refuses
    if (st.push && !fifo_ready) begin
      next_st.overrun = 1'b1;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (RST_I) begin
      st <= '0;
      st.busy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign BOOT_BUSY_O = st.busy;
  assign OVERRUN_O = st.overrun;

  sample_fifo #(
    .WIDTH(STEREO_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_sample_fifo (
    .clock_i(CLOCK_I),
    .rst_i(RST_I),
    .in_valid_i(st.push),
    .in_data_i(st.push_data),
    .in_ready_o(fifo_ready),
    .out_valid_o(SAMPLE_VALID_O),
    .out_data_o(SAMPLE_O),
    .out_ready_i(SAMPLE_READY_I)
  );
endmodule : audio_serial_rx
`default_nettype wire

/* File: design/sample_fifo.sv */
// first-in first-out buffer with registered output stage
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 8
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
    logic out_valid;
    logic [WIDTH-1:0] out_data;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic [AW:0] count;
  logic full;
  logic empty;

  assign count = st.wr - st.rd;
  assign full = (count == (AW+1)'(DEPTH));
  assign empty = (st.wr == st.rd);
  assign in_ready_o = ~full;
  assign out_valid_o = st.out_valid;
  assign out_data_o = st.out_data;

  always_comb begin
    next_st = st;
    // store on the filling side
    if (in_valid_i && !full) begin
      next_st.mem[st.wr[AW-1:0]] = in_data_i;
      next_st.wr = st.wr + 1'b1;
    end
    // drain into output register
    if (st.out_valid && out_ready_i) begin
      next_st.out_valid = 1'b0;
    end
    if (!empty && (!st.out_valid || out_ready_i)) begin
      next_st.out_data = st.mem[st.rd[AW-1:0]];
      next_st.out_valid = 1'b1;
      next_st.rd = st.rd + 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : sample_fifo
`default_nettype wire

/* File: sim/audio_link_source.sv */
// behavioural serial audio source on the link pins
`timescale 1ns/1ps
`default_nettype none
module audio_link_source
  import audio_rx_pkg::*;
(
  output logic bclk_o,
  output logic ws_o,
  output logic sdata_o
);
  initial begin
    bclk_o = 1'b0;
    ws_o = 1'b0;
    sdata_o = 1'b0;
  end
  task automatic slot(input logic w, input logic d, input logic dsp);
    bclk_o = dsp;
    ws_o = w;
    sdata_o = d;
    #40 bclk_o = !dsp;
    #40 bclk_o = dsp;
  endtask : slot
  // msb first, left first, 64 clocks
  task automatic send(input logic [1:0] m, input logic [5:0] s, input logic [5:0] n,
      input stereo_t q);
    logic [23:0] w;
    for (int c = 0; c < 2; c++) begin
      w = c ? q.right : q.left;
      for (int i = 0; i < 32; i++) begin
        slot((m == MODE_DSP) ? i == 0 : (m != MODE_I2S) ^ c[0],
          (i >= s && i < s + n) ? w[23 + s - i] : 1'b1, m == MODE_DSP);
      end
    end
  endtask : send
  // one framing bit, then data line flips while idle
  task automatic mark(input logic [1:0] m, input logic lead);
    slot(lead ^ (m == MODE_I2S), 1'b0, m == MODE_DSP);
    sdata_o = 1'b1;
  endtask : mark
endmodule : audio_link_source
`default_nettype wire

/* File: sim/audio_serial_rx_bench.sv */
// self-checking bench for the serial audio input port
`timescale 1ns/1ps
`default_nettype none
module audio_serial_rx_bench
  import audio_rx_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = MODE_I2S;
  logic [1:0] wlen = WLEN_24;
  logic ready = 1'b1;
  logic busy, ovr, valid, bclk, ws, sd;
  stereo_t smp;
  stereo_t got[$];
  int errors = 0;
  int checks = 0;
  int drops = 0;
  always #5 clk = !clk;
  audio_serial_rx u_audio_serial_rx (.CLOCK_I(clk), .RST_I(rst), .BCLK_I(bclk), .WS_I(ws),
    .SDATA_I(sd), .MODE_I(mode), .WORD_LEN_I(wlen), .BOOT_BUSY_O(busy), .OVERRUN_O(ovr),
    .SAMPLE_VALID_O(valid), .SAMPLE_O(smp), .SAMPLE_READY_I(ready));
  audio_link_source u_audio_link_source (.bclk_o(bclk), .ws_o(ws), .sdata_o(sd));
  always @(posedge clk) begin
    if (valid === 1'b1 && ready === 1'b1) got.push_back(smp);
    if (ovr === 1'b1) drops++;
  end
  task automatic complete_run;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic cmp(input string what, input logic [47:0] exp, input logic [47:0] seen);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : cmp
  function automatic stereo_t pat(input int i);
    pat.left = 24'h8C3A51 + 24'h13579B * i[23:0];
    pat.right = ~pat.left ^ 24'h00F0F0;
  endfunction : pat
  task automatic boot_check;
    int n = 0;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    cmp("busy in reset", 48'h1, {47'h0, busy});
    rst = 1'b0;
    while (busy === 1'b1 && n < 2000) begin
      @(negedge clk);
      n++;
    end
    cmp("boot cycles", 48'(BOOT_CYCLES), 48'(n));
  endtask : boot_check
  task automatic play(input logic [1:0] m, input logic [1:0] l, input logic [5:0] s,
      input logic [5:0] n, input int k, input logic stall);
    int e;
    int d;
    logic [23:0] z;
    e = stall ? FIFO_DEPTH + 1 : k;
    d = drops;
    z = ~((24'h1 << (6'h18 - n)) - 24'h1);
    @(negedge clk);
    mode = m;
    wlen = l;
    ready = !stall;
    repeat (4) @(negedge clk);
    got.delete();
    u_audio_link_source.mark(m, 1'b0);
    for (int i = 0; i < k; i++) u_audio_link_source.send(m, s, n, pat(i));
    u_audio_link_source.mark(m, 1'b1);
    repeat (10) @(negedge clk);
    ready = 1'b1;
    for (int t = 0; t < 400 && got.size() < e; t++) @(negedge clk);
    if (got.size() < e) begin
      errors++;
      $display("[FAIL] pair wait expected %0d seen %0d", e, got.size());
    end
    cmp("pair count", 48'(e), 48'(got.size()));
    cmp("overruns", 48'(k - e), 48'(drops - d));
    for (int i = 0; i < e; i++) cmp("pair", pat(i) & {z, z}, got[i]);
  endtask : play
  initial begin
    boot_check();
    play(MODE_I2S, WLEN_24, I2S_START, LEN_24, 2, 1'b0);
    play(MODE_RJ, WLEN_24, RJ_START_24, LEN_24, 2, 1'b0);
    play(MODE_LJ, WLEN_24, LJ_START, LEN_24, 10, 1'b1);
    play(MODE_RJ, WLEN_20, RJ_START_20, LEN_20, 2, 1'b0);
    play(MODE_DSP, WLEN_24, DSP_START + 6'h1, LEN_24, 2, 1'b0);
    play(MODE_RJ, 2'h2, RJ_START_16, LEN_16, 2, 1'b0);
    boot_check();
    play(MODE_RJ, 2'h3, RJ_START_16, LEN_16, 2, 1'b0);
    complete_run();
  end
endmodule : audio_serial_rx_bench
`default_nettype wire

/* File: sim/audio_serial_rx_checker.sv */
// assertions on the serial audio input port
`timescale 1ns/1ps
`default_nettype none
module audio_serial_rx_checker
  import audio_rx_pkg::*;
(
  input wire logic CLOCK_I,
  input wire logic RST_I,
  input wire logic [1:0] MODE_I,
  input wire logic [1:0] WORD_LEN_I,
  input wire logic BOOT_BUSY_O,
  input wire logic OVERRUN_O,
  input wire logic SAMPLE_VALID_O,
  input wire stereo_t SAMPLE_O,
  input wire logic SAMPLE_READY_I
);
  logic [10:0] cnt;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  always_ff @(posedge CLOCK_I) begin
    if (RST_I) cnt <= 11'h0;
    else if (cnt != BOOT_CYCLES) cnt <= cnt + 11'h1;
  end
  boot_len_a: assert property (BOOT_BUSY_O == (cnt != BOOT_CYCLES))
    else $error("boot period length wrong");
  busy_quiet_a: assert property (BOOT_BUSY_O |-> !SAMPLE_VALID_O && !OVERRUN_O)
    else $error("output during boot");
  reset_clear_a: assert property (disable iff (1'b0)
    RST_I |=> BOOT_BUSY_O && !SAMPLE_VALID_O && !OVERRUN_O)
    else $error("reset state wrong");
  after_boot_a: assert property ($fell(BOOT_BUSY_O) |-> (!SAMPLE_VALID_O) [*8])
    else $error("sample right after boot");
  hold_out_a: assert property (SAMPLE_VALID_O && !SAMPLE_READY_I |=>
    SAMPLE_VALID_O && $stable(SAMPLE_O))
    else $error("stalled sample changed");
  overrun_pulse_a: assert property (OVERRUN_O |=> !OVERRUN_O)
    else $error("overrun not one cycle");
  overrun_full_a: assert property (OVERRUN_O |-> $past(SAMPLE_VALID_O))
    else $error("overrun with empty buffer");
  len16_zero_a: assert property (SAMPLE_VALID_O && MODE_I == MODE_RJ && WORD_LEN_I[1]
    |-> SAMPLE_O.left[7:0] == 8'h00 && SAMPLE_O.right[7:0] == 8'h00)
    else $error("short word low bits set");
  len20_zero_a: assert property (SAMPLE_VALID_O && MODE_I == MODE_RJ
    && WORD_LEN_I == WLEN_20 |-> SAMPLE_O.left[3:0] == 4'h0 && SAMPLE_O.right[3:0] == 4'h0)
    else $error("20 bit word low bits set");
  cover property (OVERRUN_O);
  cover property (SAMPLE_VALID_O && !SAMPLE_READY_I);
  cover property ($fell(BOOT_BUSY_O));
endmodule : audio_serial_rx_checker
bind audio_serial_rx audio_serial_rx_checker u_audio_serial_rx_checker (.CLOCK_I(CLOCK_I),
  .RST_I(RST_I), .MODE_I(MODE_I), .WORD_LEN_I(WORD_LEN_I), .BOOT_BUSY_O(BOOT_BUSY_O),
  .OVERRUN_O(OVERRUN_O), .SAMPLE_VALID_O(SAMPLE_VALID_O), .SAMPLE_O(SAMPLE_O),
  .SAMPLE_READY_I(SAMPLE_READY_I));
`default_nettype wire
